// file: rtl/dcc_ctrl.sv
// dcc_ctrl.sv: serial frame intake and register control of an 18-bit converter
// assumes: host drives link_clk, shifts msb first on rising edge while frame_sel_n low
// Behaviour
// [R1] clear code register supplies the code loaded on any clear request
// [R2] clear frame: rw bit 23, address 011, data bits 19..2, resets zero
// [R3] clear code drives output under current coding, binary or twos complement
// [R4] strobe register write-only; a 1 acts like a low pin pulse
// [R5] strobe frame: address 100, bit 2 reset, bit 1 clear, bit 0 load
// [R6] software clear ignored while load strobe pin low
// [R7] software load ignored while clear pin low
// [R8] load bit moves pending value into converter register, updates output
// [R9] clear bit loads converter register from clear code, updates output
// [R10] reset bit returns device to power-on state
// [R11] power-on resets registers, tristates converter, clamps output to ground
// [R12] tristate and clamp hold until control register changes them
// [R13] host clears tristate and clamp before expecting output
// [R14] clamp 1 grounds output; tristate 1 clamp 0 floats; both 0 normal
// [R15] linearity field defaults 0000; 1100 for 20 V span
// [R16] feedback select 1 unity gain, 0 gain of two, chosen by host
// [R17] coding bit defaults 0 twos complement; 1 offset binary
// [R18] one 24-bit frame per select low, acted on at select rise; code closes it only at the first link_clk rise after select rise
`include "dcc_defs.svh"

module dcc_ctrl (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,

  // serial link
  input wire logic link_clk,
  input wire logic frame_sel_n,
  input wire logic serial_in,

  // strobe pins, active low
  input wire logic load_output_strobe_n,
  input wire logic clear_to_code_n,

  // converter code and state
  output logic [17:0] out_code,
  output dcc_pkg::dcc_out_e out_state,

  // control register levels
  output logic converter_tristate_bit,
  output logic output_clamp_bit,
  output logic feedback_resistor_select,
  output logic coding_offset_binary,
  output logic [3:0] lin_comp
);
  dcc_pkg::dcc_link_s l_q, l_d;
  dcc_pkg::dcc_core_s c_q, c_d;

  logic soft_rst_q;
  logic link_rst;

  // software reset also clears link side
  assign link_rst = reset | soft_rst_q;

  // saturating bit counter, long frames never wrap back to 24
  function automatic logic [4:0] dcc_count_next(input logic [4:0] count);
    logic [4:0] next;
    next = count;
    if (count != 5'h1F) begin
      next = count + 5'h01;
    end
    return next;
  endfunction : dcc_count_next

  // exactly 24 bits close a frame, other counts dropped [R18]
  function automatic logic dcc_frame_done(input logic [4:0] count);
    logic done;
    done = 1'b0;
    if (count == 5'(`DCC_FRAME_BITS)) begin
      done = 1'b1;
    end
    return done;
  endfunction : dcc_frame_done

  // shift one link bit in, msb first
  function automatic logic [23:0] dcc_shift_in(input logic [23:0] shift, input logic bit_in);
    logic [23:0] next;
    next = {shift[22:0], bit_in};
    return next;
  endfunction : dcc_shift_in

  // rw flag low marks a write, reads ignored
  function automatic logic dcc_frame_write(input logic [23:0] f);
    logic wr;
    wr = ~f[`DCC_RW_POS];
    return wr;
  endfunction : dcc_frame_write

  // register address field
  function automatic logic [2:0] dcc_frame_addr(input logic [23:0] f);
    logic [2:0] a;
    a = f[`DCC_ADDR_HI:`DCC_ADDR_LO];
    return a;
  endfunction : dcc_frame_addr

  // 18-bit data field [R2]
  function automatic logic [17:0] dcc_frame_data(input logic [23:0] f);
    logic [17:0] d;
    d = f[`DCC_DATA_HI:`DCC_DATA_LO];
    return d;
  endfunction : dcc_frame_data

  // control image of a control frame
  function automatic dcc_pkg::dcc_ctrl_s dcc_frame_ctrl(input logic [23:0] f);
    dcc_pkg::dcc_ctrl_s c;
    c.fb_sel = f[`DCC_CTRL_FBSEL_POS]; // [R16]
    c.tri_bit = f[`DCC_CTRL_TRI_POS]; // [R12]
    c.clamp_bit = f[`DCC_CTRL_CLAMP_POS]; // [R12]
    c.coding_offset = f[`DCC_CTRL_CODING_POS]; // [R17]
    c.lin_comp = f[`DCC_CTRL_LIN_HI:`DCC_CTRL_LIN_LO]; // [R15]
    return c;
  endfunction : dcc_frame_ctrl

  // soft load, blocked while clear pin low [R7]
  function automatic logic dcc_soft_load(input logic [23:0] f, input logic clr_low);
    logic hit;
    hit = f[`DCC_SOFT_LOAD_POS] & ~clr_low;
    return hit;
  endfunction : dcc_soft_load

  // soft clear, blocked while load pin low [R6]
  function automatic logic dcc_soft_clear(input logic [23:0] f, input logic ld_low);
    logic hit;
    hit = f[`DCC_SOFT_CLEAR_POS] & ~ld_low;
    return hit;
  endfunction : dcc_soft_clear

  // soft reset request [R10]
  function automatic logic dcc_soft_reset(input logic [23:0] f);
    logic hit;
    hit = f[`DCC_SOFT_RESET_POS];
    return hit;
  endfunction : dcc_soft_reset

  // next converter register, clear wins over load [R1] [R8] [R9]
  function automatic logic [17:0] dcc_next_dac(input logic clr, input logic ld,
    input logic [17:0] clear_code, input logic [17:0] pending, input logic [17:0] cur);
    logic [17:0] next;
    unique case ({clr, ld})
      2'b00: begin
        next = cur;
      end
      2'b01: begin
        next = pending;
      end
      2'b10: begin
        next = clear_code;
      end
      2'b11: begin
        next = clear_code;
      end
    endcase
    return next;
  endfunction : dcc_next_dac

  // offset binary passes, twos complement flips the msb [R3]
  function automatic logic [17:0] dcc_code_map(input logic offset_b, input logic [17:0] code);
    logic [17:0] mapped;
    unique case (offset_b)
      1'b1: begin
        mapped = code;
      end
      1'b0: begin
        mapped = {~code[17], code[16:0]};
      end
    endcase
    return mapped;
  endfunction : dcc_code_map

  // two-flop pin synchroniser
  function automatic logic [1:0] dcc_sync2(input logic [1:0] s, input logic pin);
    logic [1:0] next;
    next = {s[0], pin};
    return next;
  endfunction : dcc_sync2

  // three-flop toggle synchroniser
  function automatic logic [2:0] dcc_sync3(input logic [2:0] s, input logic t);
    logic [2:0] next;
    next = {s[1:0], t};
    return next;
  endfunction : dcc_sync3

  // only the two settled flops are compared
  function automatic logic dcc_tog_edge(input logic [2:0] s);
    logic edge_seen;
    edge_seen = s[2] ^ s[1];
    return edge_seen;
  endfunction : dcc_tog_edge

  // settled pin level, active low
  function automatic logic dcc_pin_low(input logic [1:0] s);
    logic low;
    low = ~s[1];
    return low;
  endfunction : dcc_pin_low

  // link domain: shift in frame, close it on the first link_clk rise after select rise [R18]
  always_comb begin
    l_d = l_q;

    if (!frame_sel_n) begin
      l_d.shift = dcc_shift_in(l_q.shift, serial_in);
      l_d.count = dcc_count_next(l_q.count);
    end else begin
      if (dcc_frame_done(l_q.count)) begin // [R18]
        l_d.frame = l_q.shift;
        l_d.toggle = ~l_q.toggle;
      end
      l_d.count = 5'h00;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // closed frame fields
  logic new_frame;
  logic [2:0] addr;
  logic is_write;
  logic [17:0] data;

  // synchronised pin levels
  logic ld_pin_low;
  logic clr_pin_low;

  // actions of this cycle
  logic do_load;
  logic do_clear;
  logic do_reset;

  // clamp wins over tristate [R14]
  function automatic dcc_pkg::dcc_out_e dcc_decode(input logic tri_b, input logic clamp_b);
    dcc_pkg::dcc_out_e st;
    unique case ({clamp_b, tri_b})
      2'b00: begin
        st = dcc_pkg::DCC_OUT_NORMAL;
      end
      2'b01: begin
        st = dcc_pkg::DCC_OUT_FLOAT;
      end
      2'b10: begin
        st = dcc_pkg::DCC_OUT_CLAMP;
      end
      2'b11: begin
        st = dcc_pkg::DCC_OUT_CLAMP;
      end
    endcase
    return st;
  endfunction : dcc_decode

  // core domain
  always_comb begin
    c_d = c_q;

    // toggle crosses by three flops, frame word stable by then
    c_d.tog_sync = dcc_sync3(c_q.tog_sync, l_q.toggle);
    c_d.ld_sync = dcc_sync2(c_q.ld_sync, load_output_strobe_n);
    c_d.clr_sync = dcc_sync2(c_q.clr_sync, clear_to_code_n);

    new_frame = dcc_tog_edge(c_q.tog_sync);
    ld_pin_low = dcc_pin_low(c_q.ld_sync);
    clr_pin_low = dcc_pin_low(c_q.clr_sync);

    addr = dcc_frame_addr(l_q.frame);
    is_write = dcc_frame_write(l_q.frame);
    data = dcc_frame_data(l_q.frame);

    // a low pin level loads or clears continuously
    do_load = ld_pin_low;
    do_clear = clr_pin_low;
    do_reset = 1'b0;

    if (new_frame && is_write) begin
      unique case (addr)
        `DCC_ADDR_DAC: begin
          c_d.pending = data;
        end
        `DCC_ADDR_CTRL: begin
          c_d.ctrl = dcc_frame_ctrl(l_q.frame); // [R12] [R15] [R16] [R17]
        end
        `DCC_ADDR_CLEAR: begin
          c_d.clear_code = data; // [R2]
        end
        `DCC_ADDR_SOFT: begin
          // write-only, acts as pin pulses [R4] [R5]
          if (dcc_soft_load(l_q.frame, clr_pin_low)) begin
            do_load = 1'b1; // [R7]
          end
          if (dcc_soft_clear(l_q.frame, ld_pin_low)) begin
            do_clear = 1'b1; // [R6]
          end
          do_reset = dcc_soft_reset(l_q.frame); // [R10]
        end
        default: begin
        end
      endcase
    end

    // clear has priority over load
    c_d.dac_reg = dcc_next_dac(do_clear, do_load, c_q.clear_code, c_d.pending, c_q.dac_reg); // [R1] [R8] [R9]

    // coding applies to clear code as any code
    c_d.out_code = dcc_code_map(c_q.ctrl.coding_offset, c_q.dac_reg); // [R3]
    c_d.out_state = dcc_decode(c_q.ctrl.tri_bit, c_q.ctrl.clamp_bit); // [R14]
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= do_reset;
    end
  end

  // power-on and software reset share defaults [R11] [R10]
  always_ff @(posedge core_clk or posedge link_rst) begin
    if (link_rst) begin
      c_q <= '0;
      c_q.ld_sync <= 2'h3;
      c_q.clr_sync <= 2'h3;
      c_q.pending <= `DCC_DAC_RESET;
      c_q.dac_reg <= `DCC_DAC_RESET;
      c_q.clear_code <= `DCC_CLEAR_RESET; // [R2]
      c_q.ctrl.tri_bit <= 1'b1; // [R11]
      c_q.ctrl.clamp_bit <= 1'b1; // [R11]
      c_q.ctrl.coding_offset <= 1'b0; // [R17]
      c_q.ctrl.lin_comp <= `DCC_LIN_RESET; // [R15]
      c_q.out_code <= 18'h2_0000;
      c_q.out_state <= dcc_pkg::DCC_OUT_CLAMP;
    end else begin
      c_q <= c_d;
    end
  end

  assign out_code = c_q.out_code;
  assign out_state = c_q.out_state;
  assign converter_tristate_bit = c_q.ctrl.tri_bit;
  assign output_clamp_bit = c_q.ctrl.clamp_bit;
  assign feedback_resistor_select = c_q.ctrl.fb_sel;
  assign coding_offset_binary = c_q.ctrl.coding_offset;
  assign lin_comp = c_q.ctrl.lin_comp;
endmodule : dcc_ctrl

// file: rtl/dcc_defs.svh
// dcc_defs.svh: offsets, field positions, reset values and counts of the converter control block
// assumes: included by the package and the design file by bare name
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_FRAME_BITS 24
`define DCC_CNT_W 5
`define DCC_RW_POS 23
`define DCC_ADDR_HI 22
`define DCC_ADDR_LO 20
`define DCC_DATA_HI 19
`define DCC_DATA_LO 2
`define DCC_ADDR_DAC 3'h1
`define DCC_ADDR_CTRL 3'h2
`define DCC_ADDR_CLEAR 3'h3
`define DCC_ADDR_SOFT 3'h4
`define DCC_SOFT_RESET_POS 2
`define DCC_SOFT_CLEAR_POS 1
`define DCC_SOFT_LOAD_POS 0
`define DCC_CTRL_FBSEL_POS 1
`define DCC_CTRL_TRI_POS 2
`define DCC_CTRL_CLAMP_POS 3
`define DCC_CTRL_CODING_POS 4
`define DCC_CTRL_LIN_LO 6
`define DCC_CTRL_LIN_HI 9
`define DCC_CLEAR_RESET 18'h0_0000
`define DCC_DAC_RESET 18'h0_0000
`define DCC_LIN_RESET 4'h0
`endif

// file: rtl/dcc_pkg.sv
// dcc_pkg.sv: types of the converter control block
// assumes: dcc_defs.svh on the include path
`include "dcc_defs.svh"
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_OUT_NORMAL = 2'h0,
    DCC_OUT_FLOAT = 2'h1,
    DCC_OUT_CLAMP = 2'h2
  } dcc_out_e;

  typedef struct packed {
    logic tri_bit;
    logic clamp_bit;
    logic coding_offset;
    logic fb_sel;
    logic [3:0] lin_comp;
  } dcc_ctrl_s;

  // link-domain state
  typedef struct packed {
    logic [23:0] shift;
    logic [4:0] count;
    logic [23:0] frame;
    logic toggle;
  } dcc_link_s;

  // core-domain state
  typedef struct packed {
    logic [2:0] tog_sync;
    logic [1:0] ld_sync;
    logic [1:0] clr_sync;
    logic [17:0] pending;
    logic [17:0] dac_reg;
    logic [17:0] clear_code;
    dcc_ctrl_s ctrl;
    logic [17:0] out_code;
    dcc_out_e out_state;
  } dcc_core_s;
endpackage : dcc_pkg

// file: dv/dcc_ctrl_assertions.sv
// dcc_ctrl_assertions.sv: output checks for dcc_ctrl
// assumes: bound into dcc_ctrl, core_clk domain
module dcc_ctrl_assertions (
  // core side
  input wire logic core_clk,
  input wire logic reset,
  input wire logic frame_sel_n,
  // pins
  input wire logic load_output_strobe_n,
  input wire logic clear_to_code_n,
  // outputs
  input wire logic [17:0] out_code,
  input wire dcc_pkg::dcc_out_e out_state,
  input wire logic converter_tristate_bit,
  input wire logic output_clamp_bit,
  input wire logic coding_offset_binary,
  input wire logic [3:0] lin_comp
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire tr = converter_tristate_bit;
  wire cl = output_clamp_bit;
  a_clamp_state: assert property (cl && $past(cl) |-> out_state == 2'h2)
    else $error("clamp not shown");
  a_float_state: assert property (tr && !cl && $past(tr) && !$past(cl) |-> out_state == 2'h1)
    else $error("float not shown");
  a_normal_state: assert property (!tr && !cl && !$past(tr) && !$past(cl) |-> out_state == 2'h0)
    else $error("normal not shown");
  a_state_legal: assert property (out_state != 2'h3)
    else $error("bad output state");
  a_reset_defaults: assert property ($past(reset) |->
    tr && cl && out_code == 18'h2_0000 && lin_comp == 4'h0 && !coding_offset_binary)
    else $error("bad defaults");
  a_ctrl_hold: assert property (!frame_sel_n [*8] |=>
    $stable({tr, cl, coding_offset_binary, lin_comp}))
    else $error("control moved");
  a_out_quiet: assert property ((!frame_sel_n && load_output_strobe_n && clear_to_code_n) [*8] |=>
    $stable(out_code))
    else $error("code moved");
  a_clear_hold: assert property ((!frame_sel_n && !clear_to_code_n) [*8] |=> $stable(out_code))
    else $error("clear not held");
endmodule : dcc_ctrl_assertions

bind dcc_ctrl dcc_ctrl_assertions chk (.core_clk(core_clk), .reset(reset), .frame_sel_n(frame_sel_n),
  .load_output_strobe_n(load_output_strobe_n), .clear_to_code_n(clear_to_code_n), .out_code(out_code),
  .out_state(out_state), .converter_tristate_bit(converter_tristate_bit), .output_clamp_bit(output_clamp_bit),
  .coding_offset_binary(coding_offset_binary), .lin_comp(lin_comp));

// file: dv/dcc_host.sv
// dcc_host.sv: host model sending frames
// assumes: link clock idles low between frames
module dcc_host (
  // serial link
  output logic link_clk,
  output logic frame_sel_n,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    frame_sel_n = 1'b1;
    serial_in = 1'b1;
  end
  // n bits msb first, one closing edge
  task send(input logic [23:0] f, input int n);
    #1.3 frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = f[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    #40 frame_sel_n = 1'b1;
    serial_in = ~serial_in;
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
  endtask : send
endmodule : dcc_host

// file: dv/dcc_ctrl_tb.sv
// dcc_ctrl_tb.sv: self-checking bench of dcc_ctrl
// assumes: dcc_host model, bound checker
module dcc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, reset, ld_n, clr_n, lk, sel_n, sdi, tr, cl, fb, cod;
  logic [17:0] code;
  logic [3:0] lin;
  dcc_pkg::dcc_out_e st;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  dcc_host host (.link_clk(lk), .frame_sel_n(sel_n), .serial_in(sdi));
  dcc_ctrl DUT (.core_clk(core_clk), .reset(reset), .link_clk(lk), .frame_sel_n(sel_n),
    .serial_in(sdi), .load_output_strobe_n(ld_n), .clear_to_code_n(clr_n), .out_code(code),
    .out_state(st), .converter_tristate_bit(tr), .output_clamp_bit(cl),
    .feedback_resistor_select(fb), .coding_offset_binary(cod), .lin_comp(lin));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  task complete_run();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task wr(input logic [23:0] f, input int n = 24);
    host.send(f, n);
    repeat (20) @(posedge core_clk);
  endtask : wr
  task pins(input logic l, input logic c);
    @(posedge core_clk);
    #1 ld_n = l;
    clr_n = c;
    repeat (10) @(posedge core_clk);
  endtask : pins
  // code, state, tri, clamp, fb, coding, lin
  task chk(input logic [27:0] e);
    logic [27:0] g;
    #1;
    g = {code, st, tr, cl, fb, cod, lin};
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
    $display("test %0d done", n_tests);
  endtask : chk
  initial begin
    reset = 1'b1;
    ld_n = 1'b1;
    clr_n = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge core_clk);
    chk({18'h2_0000, 2'h2, 4'b1100, 4'h0});
    wr(24'h20_0004);
    chk({18'h2_0000, 2'h1, 4'b1000, 4'h0});
    wr(24'h20_0302);
    chk({18'h2_0000, 2'h0, 4'b0010, 4'hc});
    wr(24'h14_8d14);
    chk({18'h2_0000, 2'h0, 4'b0010, 4'hc});
    wr(24'h40_0001);
    chk({18'h3_2345, 2'h0, 4'b0010, 4'hc});
    wr(24'h32_af34);
    pins(1'b0, 1'b1);
    wr(24'h40_0002);
    chk({18'h3_2345, 2'h0, 4'b0010, 4'hc});
    pins(1'b1, 1'b1);
    wr(24'h40_0002);
    chk({18'h2_abcd, 2'h0, 4'b0010, 4'hc});
    pins(1'b1, 1'b0);
    wr(24'h40_0001);
    chk({18'h2_abcd, 2'h0, 4'b0010, 4'hc});
    pins(1'b1, 1'b1);
    wr(24'h20_0312);
    chk({18'h0_abcd, 2'h0, 4'b0011, 4'hc});
    wr(24'ha0_0004);
    wr(24'h20_0004, 23);
    chk({18'h0_abcd, 2'h0, 4'b0011, 4'hc});
    wr(24'h40_0004);
    chk({18'h2_0000, 2'h2, 4'b1100, 4'h0});
    complete_run();
  end
endmodule : dcc_ctrl_tb
